// ===== verilog/sepc_pkg.sv
// Constants, types and register map of the serial EEPROM protocol front end
package sepc_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int POR_TIME_NS = 1000;
	localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_TIME_NS = 5000000;
	localparam int WRITE_CYC = WRITE_TIME_NS / CLK_PERIOD_NS;

	// Opcodes
	localparam logic [7:0] OPC_ENABLE_WRITES = 8'h06;
	localparam logic [7:0] OPC_DISABLE_WRITES = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_MEM_READ = 8'h03;
	localparam logic [7:0] OPC_MEM_WRITE = 8'h02;

	// Bit counts within a frame
	localparam logic [15:0] BITS_OPCODE = 16'h0008;
	localparam logic [15:0] BITS_STATUS_WRITE = 16'h0010;
	localparam logic [15:0] BITS_HEADER = 16'h0018;
	localparam logic [15:0] BITS_WRITE_MIN = 16'h0020;
	localparam logic [2:0] BIT_LAST_OF_BYTE = 3'h7;

	// Protect size codes
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_QUARTER = 2'h1;
	localparam logic [1:0] PROT_HALF = 2'h2;
	localparam logic [1:0] PROT_ALL = 2'h3;

	// Status byte on the link
	localparam int SR_BUSY = 0;
	localparam int SR_WLATCH = 1;
	localparam int SR_PROT_LO = 2;
	localparam int SR_PROT_HI = 3;
	localparam int SR_LOCK = 7;

	// Non-volatile bit positions
	localparam int NV_PROT_LO = 0;
	localparam int NV_PROT_HI = 1;
	localparam int NV_LOCK = 2;

	// Register map, word index
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam int CTRL_LINK_EN = 0;
	localparam logic CTRL_LINK_EN_RST = 1'b1;
	localparam int STAT_SEL = 8;
	localparam int STAT_HOLD = 9;
	localparam int STAT_STBY = 10;
	localparam int STAT_POR_DONE = 11;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OPC = 3'h1,
		ST_ADDR = 3'h2,
		ST_DATA = 3'h3,
		ST_OUT = 3'h4,
		ST_WAIT = 3'h5
	} sepc_state_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
		logic hold_n;
		logic wp_n;
	} sepc_pins_t;

	// Line reset values: select low so a held-low line never looks like a fall
	localparam sepc_pins_t PIN_RST = '{cs_n: 1'b0, sclk: 1'b0, mosi: 1'b0,
		hold_n: 1'b1, wp_n: 1'b1};

	typedef struct packed {
		logic stb;
		logic [15:0] addr;
		logic [7:0] data;
	} sepc_memwr_t;

endpackage

// ===== verilog/sepc_sync.sv
// Two-flop synchroniser for the link pins
`timescale 1ns/1ps
module sepc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule

// ===== verilog/sepc_ctrl.sv
// Serial EEPROM protocol front end with Avalon-MM control registers
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// How it works
// - Ignore link until power-on clear ends
// - Protect and lock bits survive reset
// - Select only on a select falling edge
// - Active when selected, standby when idle
// - Hold floats output, ignores data and clock
// - Hold enters when selected, clock low
// - Hold leaves on rise with clock low
// - Hold keeps bit count and state
// - Deselect during hold resets the protocol
// - Writes need whole bytes of clocks
// - Data changes need write latch set
// - Latch clears on disable or write end
// - Execute only when deselect follows last bit
// - Last bit per opcode; reads exempt
// - Protect code: none, quarter, half, all
// - Writes into protected region are rejected
// - Lock pin freezes the protect bits when lock bit set
// - Opcodes for latch set, clear, status read
// - Opcodes for status write, read, write
// - Unknown opcode deselects until new select
// - Shift MSB first, sample rise, drive fall
// - Output floats while deselected
// - Busy flag set during write cycle
// - Lock bit plus low pin blocks status write
module sepc_ctrl import sepc_pkg::*; #(
	parameter int ADDR_W = 11,
	parameter int PAGE_BYTES = 32,
	parameter int WRITE_CYCLES = WRITE_CYC,
	parameter logic [2:0] NV_INIT = 3'h0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic spi_hold_n,
	input wire logic spi_wp_n,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	output sepc_memwr_t mem_wr,
	output logic [ADDR_W-1:0] mem_rd_addr,
	input wire logic [7:0] mem_rd_data,
	output logic standby,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	localparam int PG_W = $clog2(PAGE_BYTES);
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam int POR_W = $clog2(POR_CYC + 1);
	localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WRITE_CYCLES - 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYC);
	localparam logic [PG_W-1:0] PG_LAST = PG_W'(PAGE_BYTES - 1);

	function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
		logic hit;
		hit = 1'b1;
		case (bp)
			PROT_NONE: hit = 1'b0;
			PROT_QUARTER: hit = &a[ADDR_W-1 -: 2];
			PROT_HALF: hit = a[ADDR_W-1];
			PROT_ALL: hit = 1'b1;
		endcase
		return hit;
	endfunction

	// Pin synchronisation
	sepc_pins_t pin_raw;
	sepc_pins_t pin_s;
	sepc_pins_t pin_prev_q;

	assign pin_raw = '{cs_n: spi_cs_n, sclk: spi_clk, mosi: spi_mosi,
		hold_n: spi_hold_n, wp_n: spi_wp_n};

	sepc_sync #(.W($bits(sepc_pins_t)), .RST_VAL(PIN_RST)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(pin_raw),
		.q(pin_s)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_prev_q <= PIN_RST;
		end else begin
			pin_prev_q <= pin_s;
		end
	end

	// State
	sepc_state_t state_q;
	logic sel_q;
	logic hold_q;
	logic por_done_q;
	logic [POR_W-1:0] por_cnt_q;
	logic link_en_q;
	logic [7:0] rx_q;
	logic [15:0] bitcnt_q;
	logic [7:0] opc_q;
	logic [15:0] addr_q;
	logic [7:0] nv_new_q;
	logic [7:0] tx_q;
	logic miso_q;
	logic miso_oe_n_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic wlatch_q;
	logic busy_q;
	logic busy_nv_q;
	logic [CNT_W-1:0] busy_cnt_q;
	logic flush_q;
	logic [PG_W-1:0] flush_idx_q;
	logic [PG_W-1:0] pg_lo_q;
	logic [PAGE_BYTES-1:0] pg_mask_q;
	logic [7:0] pg_buf_q [PAGE_BYTES];
	sepc_memwr_t mem_wr_q;
	logic standby_q;
	logic [31:0] rdata_q;
	logic wait_q;
	// Non-volatile bits: no reset, power-on value only
	logic [2:0] nv_q = NV_INIT;

	// Edge and event decode
	wire sclk_low = ~pin_s.sclk & ~pin_prev_q.sclk;
	wire active = sel_q & ~hold_q;
	wire sclk_rise = active & pin_s.sclk & ~pin_prev_q.sclk;
	wire sclk_fall = active & ~pin_s.sclk & pin_prev_q.sclk;
	wire cs_fall = ~pin_s.cs_n & pin_prev_q.cs_n;
	wire cs_rise = pin_s.cs_n & ~pin_prev_q.cs_n;
	wire hold_fall = ~pin_s.hold_n & pin_prev_q.hold_n;
	wire hold_rise = pin_s.hold_n & ~pin_prev_q.hold_n;
	wire hold_enter = sel_q & ~pin_s.cs_n & hold_fall & sclk_low;
	wire hold_leave = hold_q & hold_rise & sclk_low;
	wire select_now = cs_fall & por_done_q & link_en_q;

	wire [7:0] rx_byte = {rx_q[6:0], pin_s.mosi};
	wire byte_done = sclk_rise & (bitcnt_q[2:0] == BIT_LAST_OF_BYTE);
	wire opc_done = (state_q == ST_OPC) & byte_done;
	wire opc_known = (rx_byte == OPC_ENABLE_WRITES) | (rx_byte == OPC_DISABLE_WRITES) |
		(rx_byte == OPC_STATUS_READ) | (rx_byte == OPC_STATUS_WRITE) |
		(rx_byte == OPC_MEM_READ) | (rx_byte == OPC_MEM_WRITE);
	wire opc_drop = opc_done & (~opc_known | (busy_q & (rx_byte != OPC_STATUS_READ)));
	wire hdr_done = (state_q == ST_ADDR) & sclk_rise & (bitcnt_q == BITS_HEADER - 16'h0001);
	wire [ADDR_W-1:0] tgt_addr = addr_q[ADDR_W-1:0];

	// Frame end checks; reads carry no deselect window
	wire frame_end = cs_rise & sel_q & ~hold_q;
	wire hw_locked = nv_q[NV_LOCK] & ~pin_s.wp_n;
	wire do_wlatch_set = frame_end & (state_q == ST_WAIT) & (opc_q == OPC_ENABLE_WRITES) &
		(bitcnt_q == BITS_OPCODE);
	wire do_wlatch_clr = frame_end & (state_q == ST_WAIT) & (opc_q == OPC_DISABLE_WRITES) &
		(bitcnt_q == BITS_OPCODE);
	wire do_nv_write = frame_end & (state_q == ST_WAIT) & (opc_q == OPC_STATUS_WRITE) &
		(bitcnt_q == BITS_STATUS_WRITE) & wlatch_q & ~hw_locked;
	wire do_mem_write = frame_end & (state_q == ST_DATA) & (opc_q == OPC_MEM_WRITE) &
		(bitcnt_q >= BITS_WRITE_MIN) & (bitcnt_q[2:0] == 3'h0) & wlatch_q &
		~prot_hit(tgt_addr, nv_q[NV_PROT_HI:NV_PROT_LO]);
	wire busy_end = busy_q & (busy_cnt_q == '0);

	// Power-on clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			por_cnt_q <= '0;
			por_done_q <= 1'b0;
		end else if (!por_done_q) begin
			por_cnt_q <= por_cnt_q + 1'b1;
			por_done_q <= (por_cnt_q == POR_LAST);
		end
	end

	// Selection and hold
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			if (cs_rise || opc_drop) begin
				sel_q <= 1'b0;
			end else if (select_now) begin
				sel_q <= 1'b1;
			end
			if (cs_rise || hold_leave) begin
				hold_q <= 1'b0;
			end else if (hold_enter) begin
				hold_q <= 1'b1;
			end
		end
	end

	// Receive path: state advances on a clock edge outside hold, and to ST_OPC on select
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			bitcnt_q <= '0;
			rx_q <= '0;
			opc_q <= '0;
			addr_q <= '0;
			nv_new_q <= '0;
		end else if (cs_rise || opc_drop || !sel_q) begin
			state_q <= (select_now && !cs_rise) ? ST_OPC : ST_IDLE;
			bitcnt_q <= '0;
		end else if (sclk_rise) begin
			rx_q <= rx_byte;
			if (bitcnt_q != 16'hffff) begin
				bitcnt_q <= bitcnt_q + 16'h0001;
			end
			unique case (state_q)
				ST_IDLE: begin
					state_q <= ST_IDLE;
				end
				ST_OPC: begin
					if (byte_done) begin
						opc_q <= rx_byte;
						if (rx_byte == OPC_STATUS_READ) begin
							state_q <= ST_OUT;
						end else if (rx_byte == OPC_STATUS_WRITE) begin
							state_q <= ST_DATA;
						end else if (rx_byte == OPC_MEM_READ || rx_byte == OPC_MEM_WRITE) begin
							state_q <= ST_ADDR;
						end else begin
							state_q <= ST_WAIT;
						end
					end
				end
				ST_ADDR: begin
					addr_q <= {addr_q[14:0], pin_s.mosi};
					if (hdr_done) begin
						state_q <= (opc_q == OPC_MEM_READ) ? ST_OUT : ST_DATA;
					end
				end
				ST_DATA: begin
					if (byte_done && opc_q == OPC_STATUS_WRITE) begin
						nv_new_q <= rx_byte;
						state_q <= ST_WAIT;
					end
				end
				ST_OUT: begin
					state_q <= ST_OUT;
				end
				ST_WAIT: begin
					state_q <= ST_WAIT;
				end
			endcase
		end
	end

	// Page buffer; bytes wrap inside the page, later ones overwrite
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pg_lo_q <= '0;
			pg_mask_q <= '0;
		end else if (hdr_done && opc_q == OPC_MEM_WRITE) begin
			pg_lo_q <= addr_q[PG_W-2:0] == '0 ? {addr_q[PG_W-2:0], pin_s.mosi} :
				{addr_q[PG_W-2:0], pin_s.mosi};
			pg_mask_q <= '0;
		end else if (byte_done && state_q == ST_DATA && opc_q == OPC_MEM_WRITE && !busy_q) begin
			pg_buf_q[pg_lo_q] <= rx_byte;
			pg_mask_q[pg_lo_q] <= 1'b1;
			pg_lo_q <= pg_lo_q + 1'b1;
		end
	end

	// Transmit path for status and array reads
	wire tx_load = sclk_fall & (state_q == ST_OUT) & (bitcnt_q[2:0] == 3'h0);
	logic [7:0] sr_byte;

	always_comb begin
		sr_byte = '0;
		sr_byte[SR_BUSY] = busy_q;
		sr_byte[SR_WLATCH] = wlatch_q;
		sr_byte[SR_PROT_LO] = nv_q[NV_PROT_LO];
		sr_byte[SR_PROT_HI] = nv_q[NV_PROT_HI];
		sr_byte[SR_LOCK] = nv_q[NV_LOCK];
	end

	wire [7:0] tx_src = (opc_q == OPC_STATUS_READ) ? sr_byte : mem_rd_data;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_q <= '0;
			miso_q <= 1'b0;
			rd_addr_q <= '0;
		end else if (hdr_done) begin
			rd_addr_q <= {addr_q[ADDR_W-2:0], pin_s.mosi};
		end else if (tx_load) begin
			miso_q <= tx_src[7];
			tx_q <= {tx_src[6:0], 1'b0};
			if (opc_q == OPC_MEM_READ) begin
				rd_addr_q <= rd_addr_q + 1'b1;
			end
		end else if (sclk_fall && state_q == ST_OUT) begin
			miso_q <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// Output enable is active low; floats when deselected or held
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			miso_oe_n_q <= 1'b1;
		end else begin
			miso_oe_n_q <= ~(active & ~pin_s.cs_n & (state_q == ST_OUT));
		end
	end

	// Write latch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wlatch_q <= 1'b0;
		end else if (do_wlatch_clr || busy_end) begin
			wlatch_q <= 1'b0;
		end else if (do_wlatch_set) begin
			wlatch_q <= 1'b1;
		end
	end

	// Self-timed write cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			busy_nv_q <= 1'b0;
			busy_cnt_q <= '0;
		end else if (do_nv_write || do_mem_write) begin
			busy_q <= 1'b1;
			busy_nv_q <= do_nv_write;
			busy_cnt_q <= WR_LAST;
		end else if (busy_end) begin
			busy_q <= 1'b0;
			if (busy_nv_q && !hw_locked) begin
				nv_q <= {nv_new_q[SR_LOCK], nv_new_q[SR_PROT_HI], nv_new_q[SR_PROT_LO]};
			end
		end else if (busy_q) begin
			busy_cnt_q <= busy_cnt_q - 1'b1;
		end
	end

	// Array write-out, one byte per clock at the start of the cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flush_q <= 1'b0;
			flush_idx_q <= '0;
			mem_wr_q <= '0;
		end else begin
			mem_wr_q.stb <= flush_q & pg_mask_q[flush_idx_q];
			mem_wr_q.addr <= 16'({addr_q[ADDR_W-1:PG_W], flush_idx_q});
			mem_wr_q.data <= pg_buf_q[flush_idx_q];
			if (do_mem_write) begin
				flush_q <= 1'b1;
				flush_idx_q <= '0;
			end else if (flush_q) begin
				flush_q <= (flush_idx_q != PG_LAST);
				flush_idx_q <= flush_idx_q + 1'b1;
			end
		end
	end

	// Standby only when deselected with no write cycle running
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			standby_q <= 1'b1;
		end else begin
			standby_q <= ~sel_q & ~busy_q & pin_s.cs_n;
		end
	end

	// Avalon-MM slave, one wait cycle per access
	wire avs_req = avs_read | avs_write;
	wire hit_ctrl = (avs_address == REG_CTRL);
	wire hit_stat = (avs_address == REG_STAT);
	logic [31:0] stat_word;
	logic [31:0] ctrl_word;

	always_comb begin
		stat_word = '0;
		stat_word[7:0] = sr_byte;
		stat_word[STAT_SEL] = sel_q;
		stat_word[STAT_HOLD] = hold_q;
		stat_word[STAT_STBY] = standby_q;
		stat_word[STAT_POR_DONE] = por_done_q;
		ctrl_word = '0;
		ctrl_word[CTRL_LINK_EN] = link_en_q;
	end

	wire [31:0] rd_mux = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
			link_en_q <= CTRL_LINK_EN_RST;
		end else if (avs_req && wait_q) begin
			wait_q <= 1'b0;
			rdata_q <= avs_read ? rd_mux : rdata_q;
		end else begin
			wait_q <= 1'b1;
			if (avs_write && !wait_q && hit_ctrl && avs_byteenable[0]) begin
				link_en_q <= avs_writedata[CTRL_LINK_EN];
			end
		end
	end

	assign spi_miso = miso_q;
	assign spi_miso_oe_n = miso_oe_n_q;
	assign mem_wr = mem_wr_q;
	assign mem_rd_addr = rd_addr_q;
	assign standby = standby_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;

endmodule

// ===== bench/sepc_ctrl_asserts.sv
// Port checker for the protocol front end
`timescale 1ns/1ps
module sepc_ctrl_asserts import sepc_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_hold_n,
	input wire logic spi_miso,
	input wire logic spi_miso_oe_n,
	input wire sepc_memwr_t mem_wr,
	input wire logic standby,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Reset itself is the antecedent here, so no disable
	rst_outs_a: assert property (disable iff (1'b0) sys_rst |=> spi_miso_oe_n && standby
		&& avs_waitrequest && !mem_wr.stb) else $error("outputs not at rest after reset");
	wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer held too long");
	unmap_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 2'h1
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	float_desel_a: assert property (spi_cs_n [*6] |-> spi_miso_oe_n)
		else $error("output driven while deselected");
	float_hold_a: assert property (!spi_hold_n [*6] |-> spi_miso_oe_n)
		else $error("output driven during hold");
	stb_active_a: assert property (mem_wr.stb |-> !standby)
		else $error("array write in standby");
	stb_desel_a: assert property (mem_wr.stb |-> spi_cs_n)
		else $error("array write while selected");
	miso_steady_a: assert property (spi_clk [*3] ##0 !spi_miso_oe_n |-> $stable(spi_miso))
		else $error("output moved in clock high phase");
	stby_rise_a: assert property ($rose(standby) |-> spi_cs_n)
		else $error("standby while selected");
endmodule
bind sepc_ctrl sepc_ctrl_asserts i_chk (.clk, .sys_rst, .spi_clk, .spi_cs_n, .spi_hold_n,
	.spi_miso, .spi_miso_oe_n, .mem_wr, .standby, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest);

// ===== bench/sepc_master.sv
// Bus master model driving the serial link
`timescale 1ns/1ps
module sepc_master (
	input wire logic clk,
	input wire logic spi_miso,
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi,
	output logic spi_hold_n
);
	// Select starts low: a line held low from reset must not select
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b0;
		spi_mosi = 1'b0;
		spi_hold_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic sel();
		spi_cs_n <= 1'b0;
		tick(4);
	endtask
	// Clock stands low between frames; data line shows junk
	task automatic desel();
		tick(2);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		tick(8);
	endtask
	task automatic bits(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < n; i++) begin
			spi_mosi <= d[7 - i];
			tick(4);
			spi_clk <= 1'b1;
			tick(4);
			q = {q[6:0], spi_miso};
			spi_clk <= 1'b0;
		end
	endtask
	// Hold moves only while the clock is low
	task automatic hold(input logic h);
		tick(4);
		spi_hold_n <= h;
		tick(4);
	endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the protocol front end
`timescale 1ns/1ps
module tb_top import sepc_pkg::*;;
	logic clk;
	logic sys_rst;
	logic spi_clk, spi_cs_n, spi_mosi, spi_hold_n, miso, oe_n, standby, wait_r;
	logic wp_n;
	logic rd;
	logic wr;
	logic [1:0] addr;
	logic [31:0] wd;
	logic [3:0] be;
	logic [31:0] rdata;
	logic [10:0] rd_addr;
	sepc_memwr_t mem_wr;
	logic [15:0] wr_a;
	logic [7:0] wr_d;
	int wr_n = 0;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	sepc_ctrl #(.WRITE_CYCLES(50)) i_dut (.clk(clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n), .spi_wp_n(wp_n),
		.spi_miso(miso), .spi_miso_oe_n(oe_n), .mem_wr(mem_wr), .mem_rd_addr(rd_addr),
		.mem_rd_data(rd_addr[7:0] ^ 8'h5a), .standby(standby), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wait_r));
	sepc_master i_master (.clk(clk), .spi_miso(miso), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n));
	always @(posedge clk) begin
		if (mem_wr.stb === 1'b1) begin
			wr_n++;
			wr_a = mem_wr.addr;
			wr_d = mem_wr.data;
		end
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] q);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		be <= b;
		do begin
			@(posedge clk);
		end while (wait_r !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic st(input logic [7:0] v);
		logic [31:0] q;
		av(1'b0, REG_STAT, 32'h0, 4'hf, q);
		chk(q, {20'h0, 4'hc, v});
	endtask
	task automatic wait_idle();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			av(1'b0, REG_STAT, 32'h0, 4'hf, q);
			n++;
		end while (q[0] !== 1'b0 && n < 60);
	endtask
	task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] arg,
		output logic [7:0] q);
		i_master.sel();
		i_master.bits(op, 8, q);
		for (int i = 0; i < nb; i++)
			i_master.bits(arg[23 - 8 * i -: 8], 8, q);
		i_master.desel();
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic [7:0] s;
		i_master.tick(30);
		i_master.bits(OPC_ENABLE_WRITES, 8, s);
		i_master.desel();
		st(8'h00);
		chk({31'h0, standby}, 32'h1);
		av(1'b1, REG_CTRL, 32'h0, 4'h0, q);
		av(1'b0, REG_CTRL, 32'h0, 4'hf, q);
		chk(q, 32'h1);
		av(1'b1, 2'h2, 32'hffff_ffff, 4'hf, q);
		av(1'b0, 2'h2, 32'h0, 4'hf, q);
		chk(q, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_latch();
		logic [7:0] s;
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		st(8'h02);
		cmd(OPC_STATUS_READ, 1, 24'h0, s);
		chk({24'h0, s}, 32'h02);
		cmd(OPC_DISABLE_WRITES, 0, 24'h0, s);
		st(8'h00);
		$display("t_latch done");
	endtask
	task automatic t_swrite();
		logic [31:0] q;
		logic [7:0] s;
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		i_master.sel();
		i_master.bits(OPC_STATUS_WRITE, 8, s);
		i_master.bits(8'h08, 7, s);
		i_master.desel();
		st(8'h02);
		cmd(OPC_STATUS_WRITE, 1, 24'h080000, s);
		av(1'b0, REG_STAT, 32'h0, 4'hf, q);
		chk({31'h0, q[0]}, 32'h1);
		chk({31'h0, standby}, 32'h0);
		wait_idle();
		st(8'h08);
		cmd(OPC_MEM_WRITE, 3, 24'h0100a5, s);
		wait_idle();
		chk(32'(wr_n), 32'h0);
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_MEM_WRITE, 3, 24'h05003c, s);
		wait_idle();
		chk(32'(wr_n), 32'h0);
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_MEM_WRITE, 3, 24'h03ffa5, s);
		wait_idle();
		chk({8'h0, wr_a, wr_d}, 32'h03ffa5);
		chk(32'(wr_n), 32'h1);
		st(8'h08);
		$display("t_swrite done");
	endtask
	task automatic t_read();
		logic [7:0] s;
		cmd(OPC_MEM_READ, 3, 24'h012300, s);
		chk({24'h0, s}, 32'h79);
		$display("t_read done");
	endtask
	task automatic t_hold();
		logic [7:0] s;
		i_master.sel();
		i_master.bits(8'h00, 4, s);
		i_master.hold(1'b0);
		i_master.bits(8'hff, 4, s);
		i_master.hold(1'b1);
		i_master.bits(8'h60, 4, s);
		i_master.desel();
		st(8'h0a);
		i_master.sel();
		i_master.bits(OPC_DISABLE_WRITES, 8, s);
		i_master.hold(1'b0);
		i_master.desel();
		i_master.hold(1'b1);
		st(8'h0a);
		$display("t_hold done");
	endtask
	task automatic t_badop();
		logic [7:0] s;
		i_master.sel();
		i_master.bits(8'hff, 8, s);
		i_master.bits(OPC_STATUS_READ, 8, s);
		i_master.tick(4);
		chk({31'h0, oe_n}, 32'h1);
		i_master.desel();
		cmd(OPC_DISABLE_WRITES, 0, 24'h0, s);
		st(8'h08);
		$display("t_badop done");
	endtask
	task automatic t_lock();
		logic [7:0] s;
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_STATUS_WRITE, 1, 24'h880000, s);
		wait_idle();
		sys_rst <= 1'b1;
		i_master.tick(2);
		sys_rst <= 1'b0;
		i_master.tick(30);
		st(8'h88);
		wp_n <= 1'b0;
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_STATUS_WRITE, 1, 24'h000000, s);
		wait_idle();
		st(8'h8a);
		wp_n <= 1'b1;
		cmd(OPC_STATUS_WRITE, 1, 24'h000000, s);
		wait_idle();
		st(8'h00);
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_STATUS_WRITE, 1, 24'h040000, s);
		wait_idle();
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_MEM_WRITE, 3, 24'h06003c, s);
		wait_idle();
		chk(32'(wr_n), 32'h1);
		cmd(OPC_ENABLE_WRITES, 0, 24'h0, s);
		cmd(OPC_MEM_WRITE, 3, 24'h05ff3c, s);
		wait_idle();
		chk({8'h0, wr_a, wr_d}, 32'h05ff3c);
		$display("t_lock done");
	endtask
	initial begin
		sys_rst <= 1'b1;
		wp_n <= 1'b1;
		rd <= 1'b0;
		wr <= 1'b0;
		addr <= 2'h0;
		wd <= 32'h0;
		be <= 4'h0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_latch();
		t_swrite();
		t_read();
		t_hold();
		t_badop();
		t_lock();
		conclude();
	end
endmodule
